// File: rtl/fsk_data_queue.sv
// Byte queue, bit shifter, pattern detector and pin mapping of the FSK path.
//
// Local design decisions: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module fsk_data_queue #(
  parameter int unsigned BIT_CYCLES = fsk_pkg::BIT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fsk_pkg::fsk_mode_t mode,
  input  wire logic              mode_settled,
  input  wire logic              continuous_mode,
  input  wire logic              host_wr,
  input  wire logic [7:0]        host_wr_data,
  input  wire logic              host_rd,
  output logic [7:0]             host_rd_data,
  input  wire logic              overflow_clr,
  input  wire logic [5:0]        queue_threshold_reg,
  input  wire logic              pattern_detect_on,
  input  wire logic [2:0]        pattern_length,
  input  wire logic [63:0]       pattern_value,
  input  wire logic [7:0]        pin_map_reg_a,
  input  wire logic [7:0]        pin_map_reg_b,
  input  wire logic              demod_bit,
  input  wire logic              demod_clk,
  input  wire logic              serial_data_in,
  input  wire logic              synth_locked,
  input  wire logic              temp_or_battery_alert,
  input  wire logic              signal_or_preamble_hit,
  input  wire logic              rx_timeout,
  input  wire logic              ref_clock_out,
  output logic                   mod_bit,
  output logic                   queue_drained,
  output logic                   queue_packed,
  output logic                   queue_overflow_flag,
  output logic                   queue_level_irq,
  output logic                   frame_tx_done,
  output logic                   pattern_match_flag,
  output logic                   tx_path_ready,
  output logic                   bit_clock_out,
  output logic [5:0]             pin_out,
  output logic [5:0]             pin_oe
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] dbit_sync_r;
  logic [1:0] bit_clock_out_sync_r;
  logic [1:0] sdin_sync_r;
  logic       bit_clock_out_prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbit_sync_r <= 2'h0;
      bit_clock_out_sync_r <= 2'h0;
      sdin_sync_r <= 2'h0;
      bit_clock_out_prev_r <= 1'b0;
    end else begin
      dbit_sync_r <= {dbit_sync_r[0], demod_bit};
      bit_clock_out_sync_r <= {bit_clock_out_sync_r[0], demod_clk};
      sdin_sync_r <= {sdin_sync_r[0], serial_data_in};
      bit_clock_out_prev_r <= bit_clock_out_sync_r[1];
    end
  end

  logic rx_bit_stb;
  assign rx_bit_stb = bit_clock_out_sync_r[1] & ~bit_clock_out_prev_r;

  // ---------------------------------------------------------------------------
  // Mode tracking and queue clearing
  // ---------------------------------------------------------------------------
  fsk_pkg::fsk_mode_t mode_prev_r;
  logic               is_rx;
  logic               is_tx;
  logic               was_rx;
  logic               was_tx;
  logic               mode_clear;

  assign is_rx  = (mode == fsk_pkg::FSK_MODE_RX);
  assign is_tx  = (mode == fsk_pkg::FSK_MODE_TX);
  assign was_rx = (mode_prev_r == fsk_pkg::FSK_MODE_RX);
  assign was_tx = (mode_prev_r == fsk_pkg::FSK_MODE_TX);

  // idle moves and idle to Tx keep contents
  always_comb begin
    mode_clear = 1'b0;
    if (mode != mode_prev_r) begin
      if (was_tx)
        mode_clear = 1'b1;
      else if (is_rx && !was_rx)
        mode_clear = 1'b1;
      else if (was_rx && is_tx)
        mode_clear = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      mode_prev_r <= fsk_pkg::FSK_MODE_SLEEP;
    else
      mode_prev_r <= mode;
  end

  // ---------------------------------------------------------------------------
  // Byte queue
  // ---------------------------------------------------------------------------
  localparam int unsigned AW = fsk_pkg::QUEUE_AW;

  logic [7:0]  mem_r [fsk_pkg::QUEUE_DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          push_req;
  logic [7:0]    push_data;
  logic          push;
  logic          pop;
  logic          flush;
  logic          rx_byte_stb;
  logic [7:0]    rx_byte;
  logic          tx_load;

  // packed only when every entry is used
  assign queue_packed  = (count_r == 7'(fsk_pkg::QUEUE_DEPTH));
  // drained only when nothing is stored
  assign queue_drained = (count_r == 7'h00);

  assign push_req  = is_rx ? rx_byte_stb : host_wr;
  assign push_data = is_rx ? rx_byte : host_wr_data;
  // drop the byte written into a packed queue
  assign push  = push_req & ~queue_packed & ~continuous_mode;
  // a read takes its byte at the strobe that starts it
  assign pop   = (host_rd | tx_load) & ~queue_drained;
  // overflow clear also empties the queue
  assign flush = mode_clear | overflow_clr;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (push)
      mem_r[wr_ptr_r] <= push_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      host_rd_data <= 8'h00;
    else if (host_rd && !queue_drained)
      host_rd_data <= mem_r[rd_ptr_r];
  end

  // Overflow: a new overflow in the clearing cycle wins over the clear.
  // sticky overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      queue_overflow_flag <= 1'b0;
    else if (push_req && queue_packed && !continuous_mode)
      queue_overflow_flag <= 1'b1;
    else if (overflow_clr)
      queue_overflow_flag <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Level indication
  // ---------------------------------------------------------------------------
  logic level_frozen_r;

  // re-evaluated only on a queue access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      queue_level_irq <= 1'b0;
      level_frozen_r  <= 1'b0;
    end else if (flush) begin
      queue_level_irq <= 1'b0;
      level_frozen_r  <= 1'b0;
    end else begin
      if (queue_packed)
        level_frozen_r <= 1'b1;
      else if (queue_drained)
        level_frozen_r <= 1'b0;
      if ((push || pop) && !level_frozen_r && !queue_packed)
        queue_level_irq <= (count_nxt > {1'b0, queue_threshold_reg});
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit shifter
  // ---------------------------------------------------------------------------
  localparam int unsigned BCW = $clog2(BIT_CYCLES + 1);

  logic [BCW-1:0] bit_cnt_r;
  logic           bit_tick;
  logic [7:0]     tx_shift_r;
  logic [3:0]     tx_left_r;
  logic           tx_busy;

  assign bit_tick = is_tx && (bit_cnt_r == BCW'(BIT_CYCLES - 1));
  assign tx_busy  = (tx_left_r != 4'h0);
  assign tx_load  = bit_tick && !continuous_mode &&
                    (tx_left_r <= 4'h1) && !queue_drained;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      bit_cnt_r <= '0;
    else if (!is_tx || bit_tick)
      bit_cnt_r <= '0;
    else
      bit_cnt_r <= bit_cnt_r + 1'b1;
  end

  // MSB first at the bit rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift_r <= 8'h00;
      tx_left_r  <= 4'h0;
    end else if (!is_tx) begin
      tx_left_r  <= 4'h0;
    end else if (bit_tick && !continuous_mode) begin
      if (tx_load) begin
        tx_shift_r <= mem_r[rd_ptr_r];
        tx_left_r  <= 4'h8;
      end else if (tx_busy) begin
        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
        tx_left_r  <= tx_left_r - 1'b1;
      end
    end
  end

  // continuous Tx samples the serial pin each bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      mod_bit <= 1'b0;
    else if (bit_tick)
      mod_bit <= continuous_mode ? sdin_sync_r[1] :
                 (tx_load ? mem_r[rd_ptr_r][7] : tx_shift_r[6]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      frame_tx_done <= 1'b0;
    else if (!is_tx)
      frame_tx_done <= 1'b0;
    else if (bit_tick && tx_left_r == 4'h1 && queue_drained)
      frame_tx_done <= 1'b1;
  end

  assign tx_path_ready = is_tx & mode_settled;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      bit_clock_out <= 1'b0;
    else if (!is_tx)
      bit_clock_out <= bit_clock_out_sync_r[1];
    else
      bit_clock_out <= (bit_cnt_r < BCW'(BIT_CYCLES / 2));
  end

  // ---------------------------------------------------------------------------
  // Receive shifter and pattern detector
  // ---------------------------------------------------------------------------
  logic [7:0]  rx_shift_r;
  logic [2:0]  rx_cnt_r;
  logic        rx_capture;
  logic [63:0] pat_hist_r;
  logic [63:0] pat_mask;
  logic        pat_equal;

  // length field selects one to eight bytes
  // first bit sits at the top of the compared window
  always_comb begin
    pat_mask  = ~(64'hffffffffffffff00 << {pattern_length, 3'h0});
    pat_equal = ((pat_hist_r ^ (pattern_value >>
                 (6'(7 - pattern_length) * 4'h8))) & pat_mask) == 64'h0;
  end

  // bytes are gathered only after a match when detection is on
  assign rx_capture = is_rx && !continuous_mode &&
                      (!pattern_detect_on || pattern_match_flag);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift_r  <= 8'h00;
      rx_cnt_r    <= 3'h0;
      rx_byte_stb <= 1'b0;
      rx_byte     <= 8'h00;
    end else begin
      rx_byte_stb <= 1'b0;
      if (!rx_capture) begin
        rx_cnt_r <= 3'h0;
      end else if (rx_bit_stb) begin
        rx_shift_r <= {rx_shift_r[6:0], dbit_sync_r[1]};
        rx_cnt_r   <= rx_cnt_r + 1'b1;
        if (rx_cnt_r == 3'h7) begin
          rx_byte     <= {rx_shift_r[6:0], dbit_sync_r[1]};
          rx_byte_stb <= 1'b1;
        end
      end
    end
  end

  // continuous compare of the incoming stream
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pat_hist_r <= 64'h0;
    else if (!is_rx)
      pat_hist_r <= 64'h0;
    else if (rx_bit_stb)
      pat_hist_r <= {pat_hist_r[62:0], dbit_sync_r[1]};
  end

  logic pat_hit;
  assign pat_hit = pattern_detect_on && is_rx && pat_equal;

  // cleared on leaving Rx or draining
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pattern_match_flag <= 1'b0;
    else if (pat_hit && !pattern_match_flag)
      pattern_match_flag <= 1'b1;
    else if (!is_rx || (pop && count_nxt == '0) || flush)
      pattern_match_flag <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Pin mapping
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] map_code(input logic [7:0] reg_v,
                                          input int unsigned lsb);
    map_code = reg_v[lsb +: 2];
  endfunction : map_code

  logic [5:0] pin_nxt;
  logic       data_now;
  logic       active;

  assign data_now = is_tx ? mod_bit : dbit_sync_r[1];
  assign active   = is_rx | is_tx;

  // code and mode select the source of each pin; pin 2 ignores its code and carries the data bit in Rx and Tx only
  always_comb begin
    pin_nxt = 6'h00;
    case (map_code(pin_map_reg_a, fsk_pkg::MAP_A_PIN0_LSB))
      2'b00:   pin_nxt[0] = is_rx ? pattern_match_flag : tx_path_ready;
      2'b01:   pin_nxt[0] = is_rx & signal_or_preamble_hit;
      2'b10:   pin_nxt[0] = is_rx ? mode_settled : tx_path_ready;
      default: pin_nxt[0] = 1'b0;
    endcase
    case (map_code(pin_map_reg_a, fsk_pkg::MAP_A_PIN1_LSB))
      2'b00:   pin_nxt[1] = active & bit_clock_out;
      2'b01:   pin_nxt[1] = is_rx & signal_or_preamble_hit;
      default: pin_nxt[1] = 1'b0;
    endcase
    pin_nxt[2] = active & data_now;
    case (map_code(pin_map_reg_a, fsk_pkg::MAP_A_PIN3_LSB))
      2'b00:   pin_nxt[3] = is_rx & rx_timeout;
      2'b01:   pin_nxt[3] = is_rx & signal_or_preamble_hit;
      2'b11:   pin_nxt[3] = temp_or_battery_alert;
      default: pin_nxt[3] = 1'b0;
    endcase
    case (map_code(pin_map_reg_b, fsk_pkg::MAP_B_PIN4_LSB))
      2'b00:   pin_nxt[4] = active & temp_or_battery_alert;
      2'b01:   pin_nxt[4] = active & synth_locked;
      2'b10:   pin_nxt[4] = is_rx & rx_timeout;
      default: pin_nxt[4] = mode_settled;
    endcase
    case (map_code(pin_map_reg_b, fsk_pkg::MAP_B_PIN5_LSB))
      2'b00:   pin_nxt[5] = ref_clock_out;
      2'b01:   pin_nxt[5] = active & synth_locked;
      2'b10:   pin_nxt[5] = is_rx & signal_or_preamble_hit;
      default: pin_nxt[5] = mode_settled;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pin_out <= 6'h00;
    else
      pin_out <= pin_nxt;
  end

  // The data pin turns round in continuous Tx so the host can drive it.
  // live data on the serial pin
  assign pin_oe = {3'h7, ~(continuous_mode & is_tx), 2'h3};

endmodule : fsk_data_queue

`default_nettype wire

// File: rtl/fsk_pkg.sv
// Package of constants and types for the FSK data queue and pattern block.
package fsk_pkg;

  // ---------------------------------------------------------------------------
  // Chip modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FSK_MODE_SLEEP = 3'b000,
    FSK_MODE_STDBY = 3'b001,
    FSK_MODE_FSTX  = 3'b010,
    FSK_MODE_TX    = 3'b011,
    FSK_MODE_FSRX  = 3'b100,
    FSK_MODE_RX    = 3'b101
  } fsk_mode_t;

  // ---------------------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned QUEUE_DEPTH       = 64;
  localparam int unsigned QUEUE_AW          = 6;
  localparam logic [5:0]  THRESHOLD_RST     = 6'h0f;
  localparam logic [2:0]  PATTERN_LEN_RST   = 3'h3;
  localparam logic [7:0]  PIN_MAP_A_RST     = 8'h00;
  localparam logic [7:0]  PIN_MAP_B_RST     = 8'h00;

  // ---------------------------------------------------------------------------
  // Pin mapping field positions (two bits per pin)
  // ---------------------------------------------------------------------------
  localparam int unsigned MAP_A_PIN0_LSB    = 6;
  localparam int unsigned MAP_A_PIN1_LSB    = 4;
  localparam int unsigned MAP_A_PIN2_LSB    = 2;
  localparam int unsigned MAP_A_PIN3_LSB    = 0;
  localparam int unsigned MAP_B_PIN4_LSB    = 6;
  localparam int unsigned MAP_B_PIN5_LSB    = 4;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned BIT_PERIOD_NS     = 4000;
  localparam int unsigned BIT_CYCLES        = BIT_PERIOD_NS / CLK_PERIOD_NS;

endpackage : fsk_pkg

// File: sim/fsk_data_queue_bench.sv
// Self-checking bench for the FSK data queue and pattern block.
`timescale 1ns/1ps
`default_nettype none

module fsk_data_queue_bench;
  logic clk, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, overflow_clr = 1'b0;
  logic mode_settled = 1'b1, continuous_mode = 1'b0, pattern_detect_on = 1'b0;
  logic serial_data_in = 1'b0, synth_locked = 1'b0, rx_timeout = 1'b0;
  logic temp_or_battery_alert = 1'b0, signal_or_preamble_hit = 1'b0;
  logic ref_clock_out = 1'b0, demod_bit, demod_clk, mod_bit, queue_drained;
  logic queue_packed, queue_overflow_flag, queue_level_irq, frame_tx_done;
  logic pattern_match_flag, tx_path_ready, bit_clock_out;
  fsk_pkg::fsk_mode_t mode = fsk_pkg::FSK_MODE_STDBY;
  logic [7:0]  host_wr_data = 8'h00, pin_map_reg_a = 8'h00;
  logic [7:0]  pin_map_reg_b = 8'h00, host_rd_data, tx_seen, d;
  logic [5:0]  queue_threshold_reg = 6'h0f, pin_out, pin_oe, thr;
  logic [2:0]  pattern_length = 3'h0;
  logic [63:0] pattern_value = 64'h0;
  logic [7:0]  exp_q[$];
  int          bad_count = 0, checks_done = 0, cycles = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fsk_data_queue #(.BIT_CYCLES(4)) fsk_data_queue_i (
    .clk, .rst, .mode, .mode_settled, .continuous_mode, .host_wr,
    .host_wr_data, .host_rd, .host_rd_data, .overflow_clr,
    .queue_threshold_reg, .pattern_detect_on, .pattern_length, .pattern_value,
    .pin_map_reg_a, .pin_map_reg_b, .demod_bit, .demod_clk, .serial_data_in,
    .synth_locked, .temp_or_battery_alert, .signal_or_preamble_hit,
    .rx_timeout, .ref_clock_out, .mod_bit, .queue_drained, .queue_packed,
    .queue_overflow_flag, .queue_level_irq, .frame_tx_done,
    .pattern_match_flag, .tx_path_ready, .bit_clock_out, .pin_out, .pin_oe
  );
  fsk_link_model fsk_link_model_i (
    .clk, .mod_bit, .bit_clock_out, .demod_bit, .demod_clk, .tx_seen
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    {serial_data_in, synth_locked, rx_timeout, temp_or_battery_alert,
     signal_or_preamble_hit, ref_clock_out} <= 6'($urandom);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic logic lvl(input int cnt, input int t);
    return cnt > t;
  endfunction : lvl

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic push(input logic [7:0] b);
    @(posedge clk);
    host_wr <= 1'b1;
    host_wr_data <= b;
    @(posedge clk);
    host_wr <= 1'b0;
    @(negedge clk);
  endtask : push

  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      @(negedge clk);
      chk(host_rd_data, exp_q.pop_front());
      chk(queue_drained, exp_q.size() == 0);
    end
  endtask : drain

  // the queue is left alone for four clocks after the new mode is applied.
  task automatic set_mode(input fsk_pkg::fsk_mode_t m);
    @(posedge clk);
    mode <= m;
    tick(4);
  endtask : set_mode

  task automatic tally_and_finish;
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(30));
    // no pattern byte is ever zero.
    pattern_value = {8'($urandom) | 8'h01, 56'h5a3c96e1a5c369};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 64; i++) begin
      chk(queue_packed, 1'b0);
      d = 8'($urandom);
      exp_q.push_back(d);
      push(d);
    end
    chk(queue_packed, 1'b1);
    push(8'hee);
    chk(queue_overflow_flag, 1'b1);
    drain(64);
    chk(queue_overflow_flag, 1'b1);
    push(8'h11);
    @(posedge clk);
    overflow_clr <= 1'b1;
    @(posedge clk);
    overflow_clr <= 1'b0;
    tick(1);
    chk(queue_overflow_flag, 1'b0);
    chk(queue_drained, 1'b1);
    thr = 6'(1 + $urandom % 20);
    @(posedge clk);
    queue_threshold_reg <= thr;
    for (int i = 0; i <= thr; i++) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      push(d);
      chk(queue_level_irq, lvl(i + 1, thr));
    end
    @(posedge clk);
    queue_threshold_reg <= 6'h3f;
    tick(3);
    chk(queue_level_irq, 1'b1);
    drain(thr + 1);
    push(8'h3c);
    set_mode(fsk_pkg::FSK_MODE_SLEEP);
    set_mode(fsk_pkg::FSK_MODE_STDBY);
    chk(queue_drained, 1'b0);
    set_mode(fsk_pkg::FSK_MODE_RX);
    chk(queue_drained, 1'b1);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      fsk_link_model_i.send_byte(d);
    end
    tick(4);
    chk(pattern_match_flag, 1'b0);
    set_mode(fsk_pkg::FSK_MODE_STDBY);
    drain(3);
    @(posedge clk);
    pattern_detect_on <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      pattern_length <= 3'(n);
      set_mode(fsk_pkg::FSK_MODE_RX);
      for (int k = 0; k <= n; k++)
        fsk_link_model_i.send_byte(pattern_value[63 - 8 * k -: 8]);
      tick(4);
      chk(pattern_match_flag, 1'b1);
      if (n == 0) begin
        d = pattern_value[63:56] ^ 8'h80;
        exp_q.push_back(d);
        fsk_link_model_i.send_byte(d);
        tick(4);
        drain(1);
        chk(pattern_match_flag, 1'b0);
      end
      set_mode(fsk_pkg::FSK_MODE_STDBY);
      chk(pattern_match_flag, 1'b0);
    end
    d = 8'($urandom);
    push(d);
    @(posedge clk);
    mode <= fsk_pkg::FSK_MODE_TX;
    for (int i = 0; i < 5000 && frame_tx_done !== 1'b1; i++)
      tick(0);
    chk(tx_seen, d);
    tick(2);
    chk(frame_tx_done, 1'b1);
    set_mode(fsk_pkg::FSK_MODE_STDBY);
    chk(queue_drained, 1'b1);
    @(posedge clk);
    continuous_mode <= 1'b1;
    pin_map_reg_b <= 8'hc0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      mode <= i < 4 ? fsk_pkg::FSK_MODE_TX : fsk_pkg::FSK_MODE_RX;
      mode_settled <= 1'($urandom);
      tick(3);
      chk(pin_out[4], mode_settled);
      chk(tx_path_ready, i < 4 && mode_settled);
      chk(pin_oe, {3'h7, i >= 4, 2'h3});
    end
    fsk_link_model_i.send_byte(8'($urandom));
    tick(4);
    tally_and_finish();
  end
endmodule : fsk_data_queue_bench

`default_nettype wire

// File: sim/fsk_data_queue_properties.sv
// Concurrent checks on the ports of the FSK data queue.
`timescale 1ns/1ps
`default_nettype none

module fsk_data_queue_properties (
  input wire logic               clk,
  input wire logic               rst,
  input wire fsk_pkg::fsk_mode_t mode,
  input wire logic               mode_settled,
  input wire logic               continuous_mode,
  input wire logic               host_wr,
  input wire logic               host_rd,
  input wire logic               overflow_clr,
  input wire logic [7:0]         pin_map_reg_a,
  input wire logic [7:0]         pin_map_reg_b,
  input wire logic               queue_drained,
  input wire logic               queue_packed,
  input wire logic               queue_overflow_flag,
  input wire logic               queue_level_irq,
  input wire logic               pattern_match_flag,
  input wire logic               tx_path_ready,
  input wire logic               bit_clock_out,
  input wire logic [5:0]         pin_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic sb;
  logic rx;
  logic tx;
  logic pins_on;
  logic ready_pin;
  assign sb = mode == fsk_pkg::FSK_MODE_STDBY;
  assign rx = mode == fsk_pkg::FSK_MODE_RX;
  assign tx = mode == fsk_pkg::FSK_MODE_TX;
  assign pins_on = continuous_mode && (rx || tx) && pin_map_reg_a[7:4] == 4'h0;
  assign ready_pin = continuous_mode && pin_map_reg_b[7:6] == 2'h3 &&
                     mode != fsk_pkg::FSK_MODE_SLEEP;

  // ------------------------------------------------------------
  // Queue flags
  // ------------------------------------------------------------
  a_flags_exclusive: assert property (!(queue_drained && queue_packed))
    else $error("drained and packed high together");
  a_overflow_on_full: assert property (sb && $past(sb) && queue_packed &&
    host_wr && !continuous_mode |=> queue_overflow_flag)
    else $error("write into packed queue did not set overflow");
  a_overflow_clear: assert property (sb && $past(sb) && overflow_clr &&
    !host_wr |=> !queue_overflow_flag && queue_drained)
    else $error("overflow clear left flag or data behind");
  a_level_held: assert property (sb && $past(sb) && !host_wr && !host_rd &&
    !overflow_clr && !$past(host_wr) && !$past(host_rd) &&
    !$past(overflow_clr) |=> $stable(queue_level_irq))
    else $error("level indication moved without queue access");
  a_match_leaves_rx: assert property (!rx && $past(rx) |->
    ##2 !pattern_match_flag)
    else $error("match flag survived leaving receive");

  // ------------------------------------------------------------
  // Pin routing
  // ------------------------------------------------------------
  a_tx_ready_level: assert property (tx_path_ready == (tx && mode_settled))
    else $error("tx ready does not follow mode");
  a_pin0_source: assert property (pins_on [*2] |-> pin_out[0] ==
    ($past(rx) ? $past(pattern_match_flag) : $past(tx_path_ready)))
    else $error("pin 0 source wrong");
  a_pin1_clock: assert property (pins_on [*2] |->
    pin_out[1] == $past(bit_clock_out))
    else $error("pin 1 does not carry bit clock");
  a_pin4_settled: assert property (ready_pin [*2] |->
    pin_out[4] == $past(mode_settled))
    else $error("pin 4 does not carry mode settled");
endmodule : fsk_data_queue_properties

bind fsk_data_queue fsk_data_queue_properties fsk_data_queue_properties_i (
  .clk, .rst, .mode, .mode_settled, .continuous_mode, .host_wr, .host_rd,
  .overflow_clr, .pin_map_reg_a, .pin_map_reg_b, .queue_drained,
  .queue_packed, .queue_overflow_flag, .queue_level_irq, .pattern_match_flag,
  .tx_path_ready, .bit_clock_out, .pin_out
);

`default_nettype wire

// File: sim/fsk_link_model.sv
// Stand-in for the demodulator and modulator beside the bit shifter.
`timescale 1ns/1ps
`default_nettype none

module fsk_link_model (
  input  wire logic       clk,
  input  wire logic       mod_bit,
  input  wire logic       bit_clock_out,
  output logic            demod_bit,
  output logic            demod_clk,
  output logic [7:0]      tx_seen
);
  logic bclk_q;

  initial begin
    demod_bit = 1'b0;
    demod_clk = 1'b0;
  end

  // clock runs only inside a frame, bits leave MSB first.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      demod_bit = b[i];
      #62.5 demod_clk = 1'b1;
      #62.5 demod_clk = 1'b0;
    end
    demod_bit = ~b[0];
  endtask : send_byte

  // the modulator takes each bit on a rising bit clock.
  always @(posedge clk) begin
    bclk_q <= bit_clock_out;
    if (bit_clock_out && !bclk_q)
      tx_seen <= {tx_seen[6:0], mod_bit};
  end
endmodule : fsk_link_model

`default_nettype wire
